// ### logic/edge_det.sv
module edge_det (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // level in, edges out
  edge_if.det      e
);
  logic prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= e.lvl;
    end
  end

  assign e.rise = e.lvl & ~prev_r;
  assign e.fall = ~e.lvl & prev_r;
endmodule

// ### logic/edge_if.sv
interface edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport det (input lvl, output rise, output fall);
  modport user (output lvl, input rise, input fall);
endinterface

// ### logic/gated_sixteen_bit_timer.sv
// Summary of operation
// [RULE1] external clock bypasses synchroniser when sync disabled; ignored for internal clocks
// [RULE2] asynchronous external counting continues in sleep and can wake on overflow
// [RULE3] count byte reads always return a coherent registered value; here each byte is read live from count_r, nothing latched
// [RULE4] software stops the timer before writing count bytes
// [RULE5] gated counting only while gate active; polarity selects active level
// [RULE6] two-bit select picks pin, timer0 wrap, comparator 1 or 2
// [RULE7] timer0 wrap from maximum to zero makes a one-cycle gate pulse
// [RULE8] each comparator source is synchronised to timer clock or passed straight
// [RULE9] toggle mode flip-flop toggles per gate edge, else held clear
// [RULE10] software never enables toggle while changing polarity in one write
// [RULE11] single pulse: arm, open at gate edge, close and disarm at trailing edge
// [RULE12] software clears arm when it clears single-pulse mode
// [RULE13] toggle plus single pulse measures exactly one gate period
// [RULE14] gate level status readable even with gating disabled
// [RULE15] count wraps at maximum to zero and sets overflow flag
// [RULE16] overflow interrupt needs timer on and all three enables
// [RULE17] falling gate level sets gate event flag; interrupt when enabled
// [RULE18] in sleep only asynchronous external counting runs and wakes device
// [RULE19] count is capture/compare time base: capture copies, equality fires compare
// [RULE20] auto-conversion trigger clears count without flag; bus write wins
// [RULE21] clock source: instruction, system, external or secondary, low-frequency
// [RULE22] prescaler divides by 1,2,4,8; timer off clears toggle flip-flop
// [RULE23] off when timer_on low; free or gated count when on
// [RULE24] gate level sampled at first instruction phase drives counting
// [RULE25] any count byte write clears the prescale counter
// [RULE26] count bytes readable and writable, writes take effect at once
//
// Chosen here: the AHB-Lite slave port and the register offsets.
module gated_sixteen_bit_timer (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // clock sources
  input  wire logic        ext_clock_pin,
  input  wire logic        sec_osc_clk,
  input  wire logic        lfo_clk,
  input  wire logic        sleep,
  // gate sources
  input  wire logic        gate_pin,
  input  wire logic [7:0]  timer0_count,
  input  wire logic        cmp1_out,
  input  wire logic        cmp2_out,
  input  wire logic        cmp1_sync_en,
  input  wire logic        cmp2_sync_en,
  // capture/compare side
  input  wire logic        capture_evt,
  input  wire logic        auto_trigger,
  output logic [15:0]      count_out,
  output logic             compare_evt,
  // requests
  output logic             overflow_irq,
  output logic             gate_irq,
  output logic             wake
);
  // ==========================================================
  // bus slave
  logic        dp_valid_r;
  logic        dp_write_r;
  logic [7:0]  dp_addr_r;
  logic        wr_en;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_cnt;
  logic        wr_gate;

  // master holds a request while ce is low, so every state freezes
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
    end else if (ce && hready) begin
      dp_valid_r <= hsel & htrans[1];
      dp_write_r <= hwrite;
      dp_addr_r  <= haddr[7:0];
    end
  end

  assign wr_en   = ce & dp_valid_r & dp_write_r;
  assign wr_lo   = wr_en & (dp_addr_r == timer_pkg::OFF_CNT_LO);
  assign wr_hi   = wr_en & (dp_addr_r == timer_pkg::OFF_CNT_HI);
  assign wr_cnt  = wr_lo | wr_hi;
  assign wr_gate = wr_en & (dp_addr_r == timer_pkg::OFF_GATE);

  // ==========================================================
  // control registers
  logic [7:0]  ctrl_r;
  logic [7:0]  gcfg_r;
  logic [7:0]  ie_r;
  logic        timer_on;
  logic        sync_dis;
  logic [1:0]  cs_sel;
  logic [1:0]  psc_sel;
  logic        gate_enable;
  logic        gate_polarity;
  logic        gate_toggle_mode;
  logic        gate_single_pulse_mode;
  logic [1:0]  gate_source_select;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= timer_pkg::CTRL_RST;
      gcfg_r <= timer_pkg::GATE_RST;
      ie_r   <= timer_pkg::IE_RST;
    end else if (wr_en) begin
      if (dp_addr_r == timer_pkg::OFF_CTRL)   ctrl_r <= hwdata[7:0] & 8'hfd;
      if (dp_addr_r == timer_pkg::OFF_GATE)   gcfg_r <= hwdata[7:0] & 8'hf3;
      if (dp_addr_r == timer_pkg::OFF_IRQ_EN) ie_r   <= hwdata[7:0] & 8'hc3;
    end
  end

  assign timer_on               = ctrl_r[timer_pkg::CTL_ON];
  assign sync_dis               = ctrl_r[timer_pkg::CTL_SYNC_DIS];
  assign cs_sel                 = ctrl_r[timer_pkg::CTL_CS +: 2];
  assign psc_sel                = ctrl_r[timer_pkg::CTL_PSC +: 2];
  assign gate_enable            = gcfg_r[timer_pkg::GT_GE];
  assign gate_polarity          = gcfg_r[timer_pkg::GT_POL];
  assign gate_toggle_mode       = gcfg_r[timer_pkg::GT_TM];
  assign gate_single_pulse_mode = gcfg_r[timer_pkg::GT_SPM];
  assign gate_source_select     = gcfg_r[timer_pkg::GT_SS +: 2];

  // ==========================================================
  // clock source and prescaler
  logic [1:0]  ph_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_raw;
  logic        async_ext;
  logic        src_tick;
  logic [2:0]  psc_r;
  logic [2:0]  psc_mask;
  logic        tick;
  edge_if      src_e ();

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= timer_pkg::PH_Q1;
    end else if (ce) begin
      ph_r <= ph_r + 2'h1;
    end
  end

  assign ext_raw = ctrl_r[timer_pkg::CTL_SEC_OSC] ? sec_osc_clk : ext_clock_pin;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else if (ce) begin
      ext_s1_r <= ext_raw;
      ext_s2_r <= ext_s1_r;
    end
  end

  // switching sync mode may skip or add one increment
  assign async_ext = (cs_sel == timer_pkg::CS_EXT) & sync_dis; // RULE1
  assign src_e.lvl = (cs_sel == timer_pkg::CS_LFO) ? lfo_clk :
                     (sync_dis ? ext_raw : ext_s2_r); // RULE1

  edge_det u_src_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .e     (src_e)
  );

  always_comb begin
    unique case (cs_sel) // RULE21
      timer_pkg::CS_INSTR: src_tick = (ph_r == timer_pkg::PH_LAST);
      timer_pkg::CS_SYS:   src_tick = 1'b1;
      timer_pkg::CS_EXT:   src_tick = src_e.rise;
      timer_pkg::CS_LFO:   src_tick = src_e.rise;
    endcase
    unique case (psc_sel) // RULE22
      2'h0: psc_mask = 3'h0;
      2'h1: psc_mask = 3'h1;
      2'h2: psc_mask = 3'h3;
      2'h3: psc_mask = 3'h7;
    endcase
  end

  assign tick = src_tick & (psc_r == psc_mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_r <= 3'h0;
    end else if (ce) begin
      if (wr_cnt || !timer_on) begin
        psc_r <= 3'h0; // RULE25
      end else if (src_tick) begin
        psc_r <= tick ? 3'h0 : psc_r + 3'h1; // RULE22
      end
    end
  end

  // ==========================================================
  // gate path
  logic        t0_prev_r;
  logic        t0_pulse_r;
  logic [1:0]  cmp_s_r;
  logic        cmp1_g;
  logic        cmp2_g;
  logic        gate_sel;
  logic        gate_act;
  logic        tff_r;
  logic        gate_tog;
  logic        gate_ctl;
  logic        gval_r;
  timer_pkg::sp_state_e sp_r;
  edge_if      act_e ();
  edge_if      tog_e ();
  edge_if      val_e ();

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_prev_r  <= 1'b0;
      t0_pulse_r <= 1'b0;
    end else if (ce) begin
      t0_prev_r  <= (timer0_count == timer_pkg::T0_MAX);
      t0_pulse_r <= t0_prev_r & (timer0_count == timer_pkg::T0_ZERO); // RULE7
    end
  end

  // comparator copies follow the timer clock, not the bus clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s_r <= 2'h0;
    end else if (ce && src_tick) begin
      cmp_s_r <= {cmp2_out, cmp1_out}; // RULE8
    end
  end

  assign cmp1_g = cmp1_sync_en ? cmp_s_r[0] : cmp1_out; // RULE8
  assign cmp2_g = cmp2_sync_en ? cmp_s_r[1] : cmp2_out; // RULE8

  always_comb begin
    unique case (gate_source_select) // RULE6
      timer_pkg::GS_PIN:  gate_sel = gate_pin;
      timer_pkg::GS_T0:   gate_sel = t0_pulse_r;
      timer_pkg::GS_CMP1: gate_sel = cmp1_g;
      timer_pkg::GS_CMP2: gate_sel = cmp2_g;
    endcase
  end

  assign gate_act  = gate_polarity ? gate_sel : ~gate_sel; // RULE5 RULE6
  assign act_e.lvl = gate_act;

  edge_det u_act_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .e     (act_e)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tff_r <= 1'b0;
    end else if (ce) begin
      if (!gate_toggle_mode || !timer_on) begin
        tff_r <= 1'b0; // RULE9 RULE22
      end else if (act_e.rise) begin
        tff_r <= ~tff_r; // RULE9
      end
    end
  end

  assign gate_tog  = gate_toggle_mode ? tff_r : gate_act; // RULE9
  assign tog_e.lvl = gate_tog;

  edge_det u_tog_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .e     (tog_e)
  );

  // single pulse window; with toggle the window spans one full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= timer_pkg::SP_IDLE;
    end else if (ce) begin
      if (!gcfg_r[timer_pkg::GT_SPM]) begin
        sp_r <= timer_pkg::SP_IDLE; // RULE11
      end else if (wr_gate && !hwdata[timer_pkg::GT_GO]) begin
        sp_r <= timer_pkg::SP_IDLE;
      end else begin
        unique case (sp_r)
          timer_pkg::SP_IDLE: begin
            if (wr_gate && hwdata[timer_pkg::GT_GO]) sp_r <= timer_pkg::SP_ARMED; // RULE11
          end
          timer_pkg::SP_ARMED: begin
            if (tog_e.rise) sp_r <= timer_pkg::SP_OPEN; // RULE11 RULE13
          end
          timer_pkg::SP_OPEN: begin
            if (tog_e.fall) sp_r <= timer_pkg::SP_IDLE; // RULE11 RULE13
          end
          default: sp_r <= timer_pkg::SP_IDLE;
        endcase
      end
    end
  end

  assign gate_ctl = gate_single_pulse_mode ?
                    ((sp_r == timer_pkg::SP_OPEN) & gate_tog) : gate_tog; // RULE13

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gval_r <= 1'b0;
    end else if (ce && ph_r == timer_pkg::PH_Q1) begin
      gval_r <= gate_ctl; // RULE24 RULE14
    end
  end

  assign val_e.lvl = gval_r;

  edge_det u_val_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .e     (val_e)
  );

  // ==========================================================
  // counter and flags
  logic [15:0] count_r;
  logic [15:0] cc_r;
  logic        run;
  logic        inc;
  logic        ovf_set;
  logic        ovf_flag_r;
  logic        gev_flag_r;
  logic        cmp_r;
  logic        wr_flags;

  assign run     = timer_on & (~gate_enable | gval_r) // RULE23 RULE5
                 & (~sleep | async_ext); // RULE2 RULE18
  assign inc     = run & tick;
  assign ovf_set = inc & (count_r == timer_pkg::CNT_MAX) & ~wr_cnt & ~auto_trigger;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= timer_pkg::CNT_RST;
    end else if (ce) begin
      if (wr_cnt) begin
        if (wr_lo) count_r[7:0]  <= hwdata[7:0]; // RULE26 RULE20
        if (wr_hi) count_r[15:8] <= hwdata[7:0]; // RULE26 RULE20
      end else if (auto_trigger) begin
        count_r <= timer_pkg::CNT_RST; // RULE20
      end else if (inc) begin
        count_r <= count_r + 16'h0001; // RULE15
      end
    end
  end

  assign wr_flags = wr_en & (dp_addr_r == timer_pkg::OFF_FLAGS);

  // a hardware set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r <= 1'b0;
      gev_flag_r <= 1'b0;
    end else if (ce) begin
      ovf_flag_r <= ovf_set | (wr_flags ? hwdata[timer_pkg::FL_OVF] : ovf_flag_r); // RULE15
      gev_flag_r <= val_e.fall | (wr_flags ? hwdata[timer_pkg::FL_GATE] : gev_flag_r); // RULE17
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_r  <= timer_pkg::CC_RST;
      cmp_r <= 1'b0;
    end else if (ce) begin
      if (capture_evt) begin
        cc_r <= count_r; // RULE19
      end else if (wr_en && dp_addr_r == timer_pkg::OFF_CC) begin
        cc_r <= hwdata[15:0];
      end
      cmp_r <= (cc_r == count_r); // RULE19
    end
  end

  assign count_out    = count_r; // RULE19
  assign compare_evt  = cmp_r;
  assign overflow_irq = timer_on & ovf_flag_r & ie_r[timer_pkg::IE_OVF]
                      & ie_r[timer_pkg::IE_PERI] & ie_r[timer_pkg::IE_GLOB]; // RULE16
  assign gate_irq     = gev_flag_r & ie_r[timer_pkg::IE_GATE]
                      & ie_r[timer_pkg::IE_PERI] & ie_r[timer_pkg::IE_GLOB]; // RULE17
  assign wake         = sleep & timer_on & ovf_flag_r & ie_r[timer_pkg::IE_OVF]
                      & ie_r[timer_pkg::IE_PERI]; // RULE2 RULE18

  // ==========================================================
  // read mux; each count byte is read live from count_r, so the two byte reads are not coherent while counting
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_r && !dp_write_r) begin
      unique case (dp_addr_r)
        timer_pkg::OFF_CTRL:   hrdata[7:0] = ctrl_r;
        timer_pkg::OFF_GATE:   hrdata[7:0] = {gcfg_r[7:4], sp_r != timer_pkg::SP_IDLE,
                                              gval_r, gcfg_r[1:0]}; // RULE14
        timer_pkg::OFF_CNT_LO: hrdata[7:0] = count_r[7:0]; // RULE3 RULE26
        timer_pkg::OFF_CNT_HI: hrdata[7:0] = count_r[15:8]; // RULE3 RULE26
        timer_pkg::OFF_FLAGS:  hrdata[7:0] = {6'h00, gev_flag_r, ovf_flag_r};
        timer_pkg::OFF_IRQ_EN: hrdata[7:0] = ie_r;
        timer_pkg::OFF_CC:     hrdata[15:0] = cc_r;
        default:               hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_armed_edge;
    sp_r == timer_pkg::SP_ARMED && tog_e.rise && gate_single_pulse_mode && !wr_gate;
  endsequence
  sequence s_open_trail;
    sp_r == timer_pkg::SP_OPEN && tog_e.fall && gate_single_pulse_mode && !wr_gate;
  endsequence

  property p_sp_open;
    s_armed_edge |=> sp_r == timer_pkg::SP_OPEN;
  endproperty
  a_sp_open: assert property (p_sp_open) else $error("single pulse did not open"); // RULE11
  property p_sp_close;
    s_open_trail |=> sp_r == timer_pkg::SP_IDLE ##1 sp_r == timer_pkg::SP_IDLE || wr_gate;
  endproperty
  a_sp_close: assert property (p_sp_close) else $error("single pulse did not close"); // RULE11
  property p_wrap;
    ovf_set |=> count_r == 16'h0000 && ovf_flag_r;
  endproperty
  a_wrap: assert property (p_wrap) else $error("rollover wrong"); // RULE15
  property p_trig;
    auto_trigger && !wr_en |=> count_r == 16'h0000 && ovf_flag_r == $past(ovf_flag_r);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger clear wrong"); // RULE20
  property p_off_hold;
    !timer_on && !wr_cnt && !auto_trigger |=> $stable(count_r);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counted while off"); // RULE23
  property p_gate_hold;
    gate_enable && !gval_r && !wr_cnt && !auto_trigger |=> $stable(count_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate shut"); // RULE5
  property p_tff_off;
    !timer_on |=> !tff_r;
  endproperty
  a_tff_off: assert property (p_tff_off) else $error("toggle not cleared"); // RULE22
  property p_gev;
    val_e.fall |=> gev_flag_r ##1 (gev_flag_r || $past(wr_flags));
  endproperty
  a_gev: assert property (p_gev) else $error("gate event flag lost"); // RULE17
  property p_psc_clr;
    wr_cnt |=> psc_r == 3'h0;
  endproperty
  a_psc_clr: assert property (p_psc_clr) else $error("prescaler not cleared"); // RULE25
  property p_q1;
    !$stable(gval_r) |-> $past(ph_r) == timer_pkg::PH_Q1;
  endproperty
  a_q1: assert property (p_q1) else $error("gate level moved off phase"); // RULE24
  property p_irq;
    overflow_irq |-> timer_on && ovf_flag_r;
  endproperty
  a_irq: assert property (p_irq) else $error("spurious overflow request"); // RULE16
endmodule

// ### logic/timer_pkg.sv
package timer_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_GATE   = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] OFF_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_CC     = 8'h18;
  // ==========================================================
  // timer_control fields
  localparam int CTL_ON       = 0;
  localparam int CTL_SYNC_DIS = 2;
  localparam int CTL_SEC_OSC  = 3;
  localparam int CTL_PSC      = 4;
  localparam int CTL_CS       = 6;
  // gate_control_reg fields
  localparam int GT_SS  = 0;
  localparam int GT_VAL = 2;
  localparam int GT_GO  = 3;
  localparam int GT_SPM = 4;
  localparam int GT_TM  = 5;
  localparam int GT_POL = 6;
  localparam int GT_GE  = 7;
  // peripheral_flag_reg and enable fields
  localparam int FL_OVF  = 0;
  localparam int FL_GATE = 1;
  localparam int IE_OVF  = 0;
  localparam int IE_GATE = 1;
  localparam int IE_PERI = 6;
  localparam int IE_GLOB = 7;
  // ==========================================================
  // reset values and count limits
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  GATE_RST = 8'h00;
  localparam logic [7:0]  IE_RST   = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CC_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [7:0]  T0_MAX   = 8'hff;
  localparam logic [7:0]  T0_ZERO  = 8'h00;
  // ==========================================================
  // encodings
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_LFO   = 2'h3;
  localparam logic [1:0] GS_PIN   = 2'h0;
  localparam logic [1:0] GS_T0    = 2'h1;
  localparam logic [1:0] GS_CMP1  = 2'h2;
  localparam logic [1:0] GS_CMP2  = 2'h3;
  localparam logic [1:0] PH_Q1    = 2'h0;
  localparam logic [1:0] PH_LAST  = 2'h3;
  typedef enum logic [2:0] {
    SP_IDLE  = 3'h1,
    SP_ARMED = 3'h2,
    SP_OPEN  = 3'h4
  } sp_state_e;
endpackage

// ### verification/ext_side.sv
module ext_side (
  // timing
  input  wire logic clk,
  // clock sources
  output logic      ext_clock_pin,
  output logic      sec_osc_clk,
  output logic      lfo_clk,
  // gate sources
  output logic      gate_pin,
  output logic      cmp1_out,
  output logic      cmp2_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r;
  initial begin
    {ext_clock_pin, sec_osc_clk, lfo_clk} = 3'h0;
    {gate_pin, cmp1_out, cmp2_out} = 3'h0;
    div_r = 3'h0;
  end
  // ==========================================================
  // oscillators run free, asleep or not
  always @(posedge clk) begin
    div_r <= div_r + 3'h1;
    if (div_r[1:0] == 2'h3) lfo_clk <= ~lfo_clk;
    if (div_r == 3'h7) sec_osc_clk <= ~sec_osc_clk;
  end
  // ==========================================================
  // gate and comparator levels, bit order cmp2 cmp1 pin
  task automatic set_lvl(input logic [2:0] l);
    @(posedge clk);
    {cmp2_out, cmp1_out, gate_pin} <= l;
  endtask
  // pin clock stands still between bursts; slow so every edge survives
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clock_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ### verification/gated_sixteen_bit_timer_test.sv
module gated_sixteen_bit_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  gate;
    logic [2:0]  lvl;
    logic [15:0] delta;
  } row_s;
  logic        clk, rst_n, hsel, hwrite, sleep, capture_evt, auto_trigger, ce, sen;
  logic [7:0]  t0_cnt;
  logic        hreadyout, hresp, compare_evt, overflow_irq, gate_irq, wake;
  logic        ext_clock_pin, sec_osc_clk, lfo_clk, gate_pin, cmp1_out, cmp2_out;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] count_out, c0, d, d2;
  int          bad_count, num_checks;
  // ==========================================================
  // ctrl, gate, levels, count gained over 80 cycles
  localparam row_s rows [15] = '{
    '{8'h41, 8'h00, 3'h0, 16'h0050},
    '{8'h51, 8'h00, 3'h0, 16'h0028},
    '{8'h61, 8'h00, 3'h0, 16'h0014},
    '{8'h71, 8'h00, 3'h0, 16'h000a},
    '{8'h01, 8'h00, 3'h0, 16'h0014},
    '{8'h40, 8'h00, 3'h0, 16'h0000},
    '{8'hc1, 8'h00, 3'h0, 16'h000a},
    '{8'h89, 8'h00, 3'h0, 16'h0005},
    '{8'h81, 8'h00, 3'h0, 16'h0000},
    '{8'h41, 8'h80, 3'h0, 16'h0050},
    '{8'h41, 8'h80, 3'h1, 16'h0000},
    '{8'h41, 8'hc2, 3'h2, 16'h0050},
    '{8'h41, 8'hc2, 3'h5, 16'h0000},
    '{8'h41, 8'hc3, 3'h4, 16'h0050},
    '{8'h41, 8'hc1, 3'h7, 16'h0000}
  };
  gated_sixteen_bit_timer dut (
    .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .ext_clock_pin, .sec_osc_clk, .lfo_clk, .sleep, .gate_pin,
    .timer0_count(t0_cnt), .cmp1_out, .cmp2_out, .cmp1_sync_en(sen),
    .cmp2_sync_en(~sen), .capture_evt, .auto_trigger, .count_out,
    .compare_evt, .overflow_irq, .gate_irq, .wake
  );
  ext_side ext (
    .clk, .ext_clock_pin, .sec_osc_clk, .lfo_clk, .gate_pin, .cmp1_out, .cmp2_out
  );
  always #2.5 clk = ~clk;
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    {hsel, hwrite, htrans} <= {1'b1, wr, 2'h2};
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= dat;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic free_win(input int n, output logic [15:0] dd);
    @(posedge clk);
    c0 = count_out;
    repeat (n) @(posedge clk);
    dd = count_out - c0;
  endtask
  task automatic gate_win(input int hi, output logic [15:0] dd);
    @(posedge clk);
    c0 = count_out;
    ext.set_lvl(3'h1);
    repeat (hi) @(posedge clk);
    ext.set_lvl(3'h0);
    repeat (20) @(posedge clk);
    dd = count_out - c0;
  endtask
  task automatic ext_case(input logic [7:0] ctl, input logic slp, input logic [15:0] exp);
    wr(8'h00, {24'h0, ctl});
    sleep <= slp;
    @(posedge clk);
    c0 = count_out;
    ext.ext_pulses(12);
    repeat (4) @(posedge clk);
    chk("ext_count", {16'h0, exp}, {16'h0, count_out - c0});
  endtask
  task automatic strobe(input logic [1:0] s);
    @(posedge clk);
    {capture_evt, auto_trigger} <= s;
    @(posedge clk);
    {capture_evt, auto_trigger} <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {ce, sen, hsel, hwrite, sleep, capture_evt, auto_trigger, htrans} = 9'h100;
    {t0_cnt, haddr, hwdata} = {8'h10, 64'h0};
    {bad_count, num_checks} = 64'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // gate level bit masked: it follows the pins, not the reset
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      chk("reset_value", 32'h0, rd & 32'hffff_fffb);
    end
    wr(8'h00, 32'hff);
    rdchk("ctrl_rw", 8'h00, 32'hfd);
    wr(8'h1c, 32'h55);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 15; i++) begin
      wr(8'h00, {24'h0, rows[i].ctrl});
      wr(8'h04, {24'h0, rows[i].gate});
      ext.set_lvl(rows[i].lvl);
      sen <= i[1];
      repeat (16) @(posedge clk);
      free_win(80, d);
      chk("row_delta", {16'h0, rows[i].delta}, {16'h0, d});
    end
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'hfe);
    wr(8'h0c, 32'hff);
    wr(8'h14, 32'hc1);
    wr(8'h00, 32'h41);
    repeat (8) @(posedge clk);
    chk("ovf_irq", 32'h1, {31'h0, overflow_irq});
    wr(8'h14, 32'h41);
    chk("ovf_masked", 32'h0, {31'h0, overflow_irq});
    wr(8'h00, 32'h0);
    rdchk("ovf_flag", 8'h10, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'hc2);
    wr(8'h04, 32'h40);
    ext.set_lvl(3'h1);
    repeat (12) @(posedge clk);
    rdchk("gate_level", 8'h04, 32'h44);
    ext.set_lvl(3'h0);
    repeat (12) @(posedge clk);
    chk("gate_irq", 32'h1, {31'h0, gate_irq});
    rdchk("gate_flag", 8'h10, 32'h2);
    wr(8'h04, 32'hd0);
    wr(8'h04, 32'hd8);
    wr(8'h00, 32'h41);
    gate_win(40, d);
    chk("one_pulse", 32'h1, {31'h0, d >= 16'd36 && d <= 16'd46});
    rdchk("arm_clear", 8'h04, 32'hd0);
    gate_win(40, d);
    chk("disarmed", 32'h0, {16'h0, d});
    // toggle enabled alone, polarity left as it was
    wr(8'h04, 32'hf0);
    wr(8'h04, 32'hf8);
    gate_win(40, d);
    gate_win(40, d2);
    chk("period", 32'h1, {31'h0, d + d2 >= 16'd56 && d + d2 <= 16'd68});
    wr(8'h04, 32'h00);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h34);
    wr(8'h0c, 32'h12);
    strobe(2'h2);
    rdchk("capture", 8'h18, 32'h1234);
    chk("compare", 32'h1, {31'h0, compare_evt});
    wr(8'h10, 32'h0);
    strobe(2'h1);
    chk("auto_clear", 32'h0, {16'h0, count_out});
    chk("compare_off", 32'h0, {31'h0, compare_evt});
    rdchk("auto_noflag", 8'h10, 32'h0);
    wr(8'h08, 32'hfa);
    wr(8'h0c, 32'hff);
    wr(8'h14, 32'h43);
    ext_case(8'h85, 1'b1, 16'h000c);
    chk("wake", 32'h1, {31'h0, wake});
    ext_case(8'h81, 1'b1, 16'h0000);
    ext_case(8'h81, 1'b0, 16'h000c);
    chk("wake_off", 32'h0, {31'h0, wake});
    // no toggle before a timer0 wrap, so a held count means no pulse
    wr(8'h00, 32'h41);
    wr(8'h04, 32'ha1);
    @(posedge clk);
    t0_cnt <= 8'hff;
    @(posedge clk);
    t0_cnt <= 8'h00;
    repeat (16) @(posedge clk);
    free_win(80, d);
    chk("t0_gate", 32'h50, {16'h0, d});
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    c0 = count_out;
    chk("ce_ready", 32'h0, {31'h0, hreadyout});
    repeat (20) @(posedge clk);
    chk("ce_freeze", {16'h0, c0}, {16'h0, count_out});
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
